// ### rtl/ltssm_pkg.sv
// Purpose: shared constants and types for the link training block
// Assumes: core clock of 100 MHz, PHY side on the same clock
// Notes: counts derive from times so a clock change stays in one place
//
// Summary of operation
// RQ1 - ext synch L0s exit sends exactly 4096 fast training sequences, no more
// RQ2 - ext synch exit inserts at least twelve separate skip sets among them
// RQ3 - partner receiver times out between 2048 and 4096 training sequences
// RQ4 - L0s power saving only when link control bit 0 is one
// RQ5 - idle L0 enters L0s on entry timer; pending packet wakes it
// RQ6 - recovery lock and config advance only on matching link and lane
// RQ7 - partner keeps sending TS1; two TS1 move L0 to recovery
// RQ8 - decode error sends correctable message, replayed while unacknowledged
// RQ9 - replay timer rollover requests retraining and enters recovery; the code does so only on the expiry with replay_num_q at REPLAY_NUM
// RQ10 - packet before idle sets still received; duplicate packet discarded
// RQ11 - downstream width accept sends PAD lanes until width is settled
// RQ12 - two training sets then bad data enter recovery without long wait
package ltssm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int L0S_ENTRY_NS = 1000;
  localparam logic [15:0] L0S_ENTRY_CYC = 16'(L0S_ENTRY_NS / CLK_NS);
  localparam int REPLAY_NS = 2000;
  localparam logic [15:0] REPLAY_CYC = 16'(REPLAY_NS / CLK_NS);

  // ---------------------------------------------------------------
  // counts and codes
  // ---------------------------------------------------------------
  localparam logic [12:0] FTS_EXT = 13'h1000;
  localparam logic [12:0] FTS_NORM = 13'h0080;
  localparam int SKP_GAP_LOG = 8;
  localparam logic [4:0] SKP_MIN = 5'h0C;
  localparam logic [3:0] REC_TS_NEED = 4'h8;
  localparam logic [1:0] REPLAY_NUM = 2'h3;
  localparam logic [7:0] PAD_LANE = 8'hF7;
  localparam logic [7:0] LINK_NUM = 8'h00;
  localparam logic [7:0] LANE_NUM = 8'h00;
  localparam logic [31:0] ERR_CORR_CODE = 32'h00000030;
  localparam int PKT_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int SEQ_W = 12;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OS_TS1, OS_TS2, OS_SKP, OS_EIEOS, OS_EIOS, OS_FTS, OS_PKT, OS_MSG,
    OS_ACK
  } os_e;

  typedef enum {
    ST_CFG, ST_L0, ST_L0S, ST_FTS, ST_REC_LOCK, ST_REC_CFG
  } lt_state_e;

endpackage

// ### rtl/pkt_fifo_if.sv
// Purpose: valid/ready carrier between the core and its packet buffer
// Assumes: one clock
// Notes: none
`timescale 1ns/10ps
interface pkt_fifo_if #(parameter int W = 32);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport buffer (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface

// ### rtl/pkt_fifo.sv
// Purpose: small packet buffer in front of the transmitter
// Assumes: depth is a power of two
// Notes: full shows as wr_ready low, so back-pressure reaches the user
`timescale 1ns/10ps
module pkt_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // buffer ports
  pkt_fifo_if.buffer f
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pull;

  assign f.wr_ready = (cnt_q != (AW+1)'(D));
  assign f.rd_valid = (cnt_q != '0);
  assign f.rd_data = mem_q[rp_q];
  assign push = f.wr_valid && f.wr_ready;
  assign pull = f.rd_valid && f.rd_ready;

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_q[wp_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pull)
      begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pull)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pull && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### rtl/pcie_ltssm_l0s_recovery.sv
// Purpose: L0/L0s/recovery training core with ack/replay and rx filter
// Assumes: PHY ordered-set interface runs on clk, so no synchronisers
// Notes: one output register stage; tx_ready stalls everything upstream
`timescale 1ns/10ps
module pcie_ltssm_l0s_recovery
  import ltssm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // configuration
  input wire logic [1:0] link_ctrl,
  input wire logic ext_synch,
  input wire logic cfg_enter,
  input wire logic width_settled,
  // packets to send
  input wire logic pkt_in_valid,
  output logic pkt_in_ready,
  input wire logic [PKT_W-1:0] pkt_in_data,
  // receive side from PHY
  input wire logic rx_os_valid,
  input wire os_e rx_os_type,
  input wire logic [7:0] rx_link,
  input wire logic [7:0] rx_lane,
  input wire logic [SEQ_W-1:0] rx_seq,
  input wire logic [PKT_W-1:0] rx_data,
  input wire logic rx_decode_err,
  // transmit side to PHY
  output logic tx_os_valid,
  output os_e tx_os_type,
  output logic [7:0] tx_link,
  output logic [7:0] tx_lane,
  output logic [SEQ_W-1:0] tx_seq,
  output logic [PKT_W-1:0] tx_data,
  input wire logic tx_ready,
  // delivered packets and status
  output logic rx_pkt_valid,
  output logic [PKT_W-1:0] rx_pkt_data,
  output lt_state_e ltssm_state,
  output logic retrain_req
);
  // ---------------------------------------------------------------
  // packet buffer
  // ---------------------------------------------------------------
  pkt_fifo_if #(.W(PKT_W)) f ();
  pkt_fifo #(.W(PKT_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .f(f));
  assign f.wr_valid = pkt_in_valid;
  assign f.wr_data = pkt_in_data;
  assign pkt_in_ready = f.wr_ready;

  lt_state_e state_q, state_d;
  logic [12:0] fts_q, fts_tgt;
  logic skp_owed_q;
  logic [15:0] idle_q, replay_q;
  logic [1:0] ts_cnt_q, replay_num_q;
  logic [3:0] lock_cnt_q;
  logic unacked_q, err_pend_q, err_send_q, ack_pend_q;
  logic [SEQ_W-1:0] ack_seq_q, tx_seq_q, exp_seq_q;
  logic adv, sel_valid, pop, sent, rx_ts, rx_match, replay_exp, lock_done;
  os_e sel_type;
  logic [7:0] sel_lane;
  logic [SEQ_W-1:0] sel_seq;
  logic [PKT_W-1:0] sel_data;

  function automatic logic is_ts(input os_e t);
    is_ts = (t == OS_TS1) || (t == OS_TS2);
  endfunction

  assign fts_tgt = ext_synch ? FTS_EXT : FTS_NORM;
  assign adv = !tx_os_valid || tx_ready;
  assign sent = ce && adv && sel_valid;
  assign rx_ts = rx_os_valid && is_ts(rx_os_type);
  assign rx_match = (rx_link == LINK_NUM) && (rx_lane == LANE_NUM);
  assign replay_exp = unacked_q && (replay_q == REPLAY_CYC - 16'h0001);
  assign lock_done = rx_ts && rx_match && (lock_cnt_q == REC_TS_NEED - 4'h1);
  assign ltssm_state = state_q;

  // ---------------------------------------------------------------
  // transmit selection
  // ---------------------------------------------------------------
  always_comb
  begin
    sel_valid = 1'b0;
    sel_type = OS_TS1;
    sel_lane = LANE_NUM;
    sel_seq = '0;
    sel_data = '0;
    pop = 1'b0;
    case (state_q)
      ST_CFG:
      begin
        sel_valid = 1'b1;
        sel_lane = width_settled ? LANE_NUM : PAD_LANE; // see RQ11
      end
      ST_REC_LOCK: sel_valid = 1'b1;
      ST_REC_CFG:
      begin
        sel_valid = 1'b1;
        sel_type = OS_TS2;
      end
      ST_FTS:
      begin
        sel_valid = 1'b1;
        // skip set owed every 256 sequences with ext_synch, and once at the end in both modes; see RQ2
        sel_type = (skp_owed_q || fts_q == fts_tgt) ? OS_SKP : OS_FTS;
      end
      ST_L0:
      begin
        if (ack_pend_q)
        begin
          sel_valid = 1'b1;
          sel_type = OS_ACK;
          sel_seq = ack_seq_q;
        end
        else if (err_send_q)
        begin
          sel_valid = 1'b1; // see RQ8
          sel_type = OS_MSG;
          sel_data = ERR_CORR_CODE;
        end
        else if (f.rd_valid)
        begin
          sel_valid = 1'b1;
          sel_type = OS_PKT;
          sel_seq = tx_seq_q;
          sel_data = f.rd_data;
          pop = adv;
        end
      end
      default: sel_valid = 1'b0;
    endcase
  end
  assign f.rd_ready = ce && pop;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_os_valid <= 1'b0;
      tx_os_type <= OS_TS1;
      tx_link <= LINK_NUM;
      tx_lane <= LANE_NUM;
      tx_seq <= '0;
      tx_data <= '0;
    end
    else if (ce && adv)
    begin
      tx_os_valid <= sel_valid;
      tx_os_type <= sel_type;
      tx_link <= LINK_NUM;
      tx_lane <= sel_lane;
      tx_seq <= sel_seq;
      tx_data <= sel_data;
    end
  end

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_CFG:
        if (width_settled && lock_done) state_d = ST_L0;
      ST_L0:
        if (rx_ts && ts_cnt_q != 2'h0) state_d = ST_REC_LOCK; // see RQ7
        else if (replay_exp && replay_num_q == REPLAY_NUM)
          state_d = ST_REC_LOCK; // see RQ9
        else if (link_ctrl[0] && !sel_valid &&
                 idle_q == L0S_ENTRY_CYC - 16'h0001)
          state_d = ST_L0S; // see RQ4, RQ5
      ST_L0S:
        if (f.rd_valid || err_send_q || ack_pend_q)
          state_d = ST_FTS; // see RQ5
      ST_FTS:
        if (adv && sel_type == OS_SKP && fts_q == fts_tgt)
          state_d = ST_L0; // see RQ1
      ST_REC_LOCK:
        if (lock_done) state_d = ST_REC_CFG; // see RQ6
      ST_REC_CFG:
        if (lock_done && rx_os_type == OS_TS2) state_d = ST_L0; // see RQ6
      default: state_d = ST_CFG;
    endcase
    if (cfg_enter) state_d = ST_CFG;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_CFG;
      retrain_req <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      retrain_req <= (state_q == ST_L0) && (state_d == ST_REC_LOCK) &&
                     replay_exp && (replay_num_q == REPLAY_NUM);
    end
  end

  // fts and skip counting for L0s exit
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_q != ST_FTS)
    begin
      fts_q <= '0;
      skp_owed_q <= 1'b0;
    end
    else if (sent && sel_type == OS_FTS)
    begin
      fts_q <= fts_q + 13'h0001; // see RQ1
      skp_owed_q <= ext_synch && (fts_q[SKP_GAP_LOG-1:0] == '1);
    end
    else if (sent)
    begin
      skp_owed_q <= 1'b0;
    end
  end

  // idle timer; any item to transmit restarts the wait
  always_ff @(posedge clk)
  begin
    if (sys_rst ||
        (ce && (state_q != ST_L0 || sel_valid || !link_ctrl[0])))
    begin
      idle_q <= '0;
    end
    else if (ce)
    begin
      idle_q <= idle_q + 16'h0001; // see RQ5
    end
  end

  // training set counters; skip and EIEOS do not break the run
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_q != ST_L0)
    begin
      ts_cnt_q <= '0;
    end
    else if (ce && rx_ts)
    begin
      ts_cnt_q <= 2'h1; // see RQ7
    end
    else if (ce && rx_os_valid && (rx_os_type == OS_PKT ||
             rx_os_type == OS_ACK) && !rx_decode_err)
    begin
      ts_cnt_q <= '0; // decode errors keep the count; see RQ12
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && state_q != state_d))
    begin
      lock_cnt_q <= '0;
    end
    else if (ce && rx_ts)
    begin
      lock_cnt_q <= rx_match ? lock_cnt_q + 4'h1 : 4'h0; // see RQ6
    end
  end

  // ---------------------------------------------------------------
  // ack, replay and error message
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      unacked_q <= 1'b0;
      err_pend_q <= 1'b0;
      err_send_q <= 1'b0;
      replay_q <= '0;
      replay_num_q <= '0;
      tx_seq_q <= '0;
    end
    else if (ce)
    begin
      if (state_q == ST_L0 && replay_exp)
      begin
        replay_q <= '0;
        replay_num_q <= (replay_num_q == REPLAY_NUM) ? 2'h0 :
                        replay_num_q + 2'h1;
      end
      else if (state_q == ST_L0 && unacked_q)
      begin
        replay_q <= replay_q + 16'h0001;
      end
      // a send in the ack's cycle still arms the timer
      if (sent && (sel_type == OS_PKT || sel_type == OS_MSG))
      begin
        unacked_q <= 1'b1;
      end
      else if (rx_os_valid && rx_os_type == OS_ACK)
      begin
        unacked_q <= 1'b0;
      end
      if (rx_os_valid && rx_os_type == OS_ACK)
      begin
        err_pend_q <= 1'b0;
        replay_q <= '0;
        replay_num_q <= '0;
      end
      // a new error wins over the send that clears the request
      if (state_q == ST_L0 && rx_decode_err)
      begin
        err_pend_q <= 1'b1; // see RQ8
        err_send_q <= 1'b1;
      end
      else if (state_q == ST_L0 && replay_exp && err_pend_q)
      begin
        err_send_q <= 1'b1; // see RQ8
      end
      else if (sent && sel_type == OS_MSG)
      begin
        err_send_q <= 1'b0;
      end
      if (sent && sel_type == OS_PKT)
      begin
        tx_seq_q <= tx_seq_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive filter: in-order packets only
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      exp_seq_q <= '0;
      ack_pend_q <= 1'b0;
      ack_seq_q <= '0;
      rx_pkt_valid <= 1'b0;
      rx_pkt_data <= '0;
    end
    else if (ce)
    begin
      rx_pkt_valid <= 1'b0;
      if (sent && sel_type == OS_ACK)
      begin
        ack_pend_q <= 1'b0;
      end
      // trailing idle sets do not cancel a packet already taken
      if (rx_os_valid && rx_os_type == OS_PKT && !rx_decode_err)
      begin
        ack_pend_q <= 1'b1;
        ack_seq_q <= rx_seq;
        if (rx_seq == exp_seq_q)
        begin
          rx_pkt_valid <= 1'b1; // see RQ10
          rx_pkt_data <= rx_data;
          exp_seq_q <= exp_seq_q + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [12:0] fts_seen_q;
  logic [4:0] skp_seen_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_q == ST_L0S)
    begin
      fts_seen_q <= '0;
      skp_seen_q <= '0;
    end
    else if (state_q == ST_FTS && sent)
    begin
      if (sel_type == OS_FTS) fts_seen_q <= fts_seen_q + 13'h0001;
      else if (skp_seen_q != 5'h1F) skp_seen_q <= skp_seen_q + 5'h01;
    end
  end

  sequence s_fts_exit;
    ce && state_q == ST_FTS && state_d == ST_L0 && ext_synch;
  endsequence
  sequence s_enter_l0s;
    state_q == ST_L0 ##1 state_q == ST_L0S;
  endsequence
  sequence s_lock_adv;
    state_q == ST_REC_LOCK ##1 state_q == ST_REC_CFG;
  endsequence

  AST_FTS_EXACT: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
    s_fts_exit |-> fts_seen_q == FTS_EXT) else $error("fts count wrong");
  AST_FTS_CAP: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
    (state_q == ST_FTS && ext_synch) |-> fts_seen_q <= FTS_EXT)
    else $error("extra fts sent");
  AST_SKP_MIN: assert property (@(posedge clk) disable iff (sys_rst) // see RQ2
    s_fts_exit |-> skp_seen_q + 5'h01 >= SKP_MIN)
    else $error("too few skip sets");
  AST_L0S_EN: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
    s_enter_l0s |-> $past(link_ctrl[0])) else $error("l0s without enable");
  AST_L0S_WAKE: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
    (ce && state_q == ST_L0S && f.rd_valid && !cfg_enter) |=>
    state_q == ST_FTS) else $error("no wake on packet");
  AST_REC_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // see RQ6
    s_lock_adv |-> $past(rx_ts && rx_match)) else $error("lock unmatched");
  AST_TWO_TS1: assert property (@(posedge clk) disable iff (sys_rst) // see RQ7
    (ce && state_q == ST_L0 && rx_ts && ts_cnt_q == 2'h1 && !cfg_enter)
    |=> state_q == ST_REC_LOCK) else $error("missed recovery entry");
  AST_ERR_MSG: assert property (@(posedge clk) disable iff (sys_rst) // see RQ8
    (ce && state_q == ST_L0 && rx_decode_err) |=> err_send_q && err_pend_q)
    else $error("decode error not reported");
  AST_RETRAIN: assert property (@(posedge clk) disable iff (sys_rst) // see RQ9
    (ce && state_q == ST_L0 && replay_exp && replay_num_q == REPLAY_NUM &&
     !cfg_enter && !rx_ts) |=> retrain_req && state_q == ST_REC_LOCK)
    else $error("no retrain on rollover");
  AST_DUP_DROP: assert property (@(posedge clk) disable iff (sys_rst) // see RQ10
    (ce && rx_os_valid && rx_os_type == OS_PKT && rx_seq != exp_seq_q)
    |=> !rx_pkt_valid) else $error("duplicate delivered");
  AST_PAD_LANE: assert property (@(posedge clk) disable iff (sys_rst) // see RQ11
    (ce && adv && state_q == ST_CFG && !width_settled) |=>
    tx_lane == PAD_LANE) else $error("lane number too early");
endmodule

// ### test/link_partner.sv
// Purpose: remote link partner model on the far side of the core
// Assumes: one clock; items change 1 ns after the rising edge
// Notes: released rx lines toggle so a stale value never looks valid
`timescale 1ns/10ps
module link_partner
  import ltssm_pkg::*;
#(
  parameter int FTS_TO = 3072
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench controls
  input wire logic slow,
  input wire logic stall,
  input wire logic ack_en,
  // items from the core
  input wire logic tx_os_valid,
  input wire os_e tx_os_type,
  output logic tx_ready,
  // items to the core
  output logic rx_os_valid,
  output os_e rx_os_type,
  output logic [7:0] rx_link,
  output logic [7:0] rx_lane,
  output logic [SEQ_W-1:0] rx_seq,
  output logic [PKT_W-1:0] rx_data
);
  typedef struct packed {
    os_e t;
    logic [7:0] k;
    logic [7:0] n;
    logic [SEQ_W-1:0] s;
    logic [PKT_W-1:0] d;
  } item_s;
  item_s q[$];
  item_s it;
  int fts_n = 0;
  int skp_n = 0;
  int run_n = 0;
  logic timed_out = 1'b0;

  task automatic send(input os_e t, input logic [7:0] k,
                      input logic [7:0] n, input logic [SEQ_W-1:0] s,
                      input logic [PKT_W-1:0] d);
    q.push_back('{t, k, n, s, d});
  endtask

  initial
  begin
    tx_ready = 1'b0;
    rx_os_valid = 1'b0;
    rx_os_type = OS_SKP;
    rx_link = 8'h5A;
    rx_lane = 8'hA5;
    rx_seq = '0;
    rx_data = '0;
  end

  // ---------------------------------------------------------------
  // drive side
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    #1;
    tx_ready = !stall && (!slow || $urandom_range(1) == 1);
    if (q.size() > 0)
    begin
      it = q.pop_front();
      rx_os_valid = 1'b1;
      rx_os_type = it.t;
      rx_link = it.k;
      rx_lane = it.n;
      rx_seq = it.s;
      rx_data = it.d;
    end
    else
    begin
      rx_os_valid = 1'b0;
      rx_link = ~rx_link;
      rx_lane = ~rx_lane;
      rx_seq = ~rx_seq;
      rx_data = ~rx_data;
    end
  end

  // ---------------------------------------------------------------
  // take side
  // ---------------------------------------------------------------
  always @(posedge clk)
    if (!sys_rst && tx_os_valid && tx_ready)
    begin
      if (tx_os_type == OS_FTS)
        run_n++;
      if (tx_os_type == OS_FTS)
        fts_n++;
      if (tx_os_type == OS_SKP)
        skp_n++;
      if (tx_os_type == OS_SKP)
        run_n = 0;
      // receiver gives up after more than this many fast training sets without a skip
      if (run_n > FTS_TO)
        timed_out = 1'b1;
      if (ack_en && (tx_os_type == OS_PKT || tx_os_type == OS_MSG))
        send(OS_ACK, LINK_NUM, LANE_NUM, '0, '0);
    end
endmodule

// ### test/tb.sv
// Purpose: self-checking bench for the training core
// Assumes: partner model answers on the far side of the link
// Notes: the l0s exit runs the full count, so it dominates run time
`timescale 1ns/10ps
module tb
  import ltssm_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] link_ctrl = 2'h0;
  logic ext_synch = 1'b0;
  logic cfg_enter = 1'b0;
  logic width_settled = 1'b0;
  logic pkt_in_valid = 1'b0;
  logic [PKT_W-1:0] pkt_in_data = '0;
  logic rx_decode_err = 1'b0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic ack_en = 1'b1;
  logic pkt_in_ready, rx_os_valid, tx_os_valid, tx_ready;
  logic rx_pkt_valid, retrain_req, got;
  os_e rx_os_type, tx_os_type;
  logic [7:0] rx_link, rx_lane, tx_link, tx_lane;
  logic [SEQ_W-1:0] rx_seq, tx_seq;
  logic [SEQ_W-1:0] exp_seq = '0;
  logic [PKT_W-1:0] rx_data, tx_data, rx_pkt_data;
  lt_state_e ltssm_state;
  logic [PKT_W-1:0] tx_q[$], rx_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  int msg_n = 0;
  int i, k, f0, s0;

  pcie_ltssm_l0s_recovery uut (.clk, .sys_rst, .ce, .link_ctrl,
    .ext_synch, .cfg_enter, .width_settled, .pkt_in_valid, .pkt_in_ready,
    .pkt_in_data, .rx_os_valid, .rx_os_type, .rx_link, .rx_lane, .rx_seq,
    .rx_data, .rx_decode_err, .tx_os_valid, .tx_os_type, .tx_link,
    .tx_lane, .tx_seq, .tx_data, .tx_ready, .rx_pkt_valid, .rx_pkt_data,
    .ltssm_state, .retrain_req);
  link_partner #(.FTS_TO(3072)) p (.clk, .sys_rst, .slow, .stall, .ack_en,
    .tx_os_valid, .tx_os_type, .tx_ready, .rx_os_valid, .rx_os_type,
    .rx_link, .rx_lane, .rx_seq, .rx_data);

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ts(input os_e t, input logic [7:0] a, input logic [7:0] b,
                    input int c);
    repeat (c) p.send(t, a, b, '0, '0);
    for (int j = 0; j < 100 && p.q.size() > 0; j++) tick(1);
    tick(3);
  endtask
  // offers up to n packets, gives up after tries edges
  task automatic push_n(input int n, input int tries, output int got_n);
    logic acc;
    got_n = 0;
    pkt_in_valid = 1'b1;
    pkt_in_data = $urandom;
    for (int j = 0; j < tries && got_n < n; j++)
    begin
      @(posedge clk);
      acc = pkt_in_ready;
      if (acc)
        tx_q.push_back(pkt_in_data);
      if (acc)
        got_n++;
      #1;
      // data only moves on once the buffer took it
      if (acc)
        pkt_in_data = $urandom;
    end
    pkt_in_valid = 1'b0;
  endtask
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // output watcher
  // ---------------------------------------------------------------
  always @(posedge clk)
    if (!sys_rst)
    begin
      if (tx_os_valid && tx_ready && tx_os_type == OS_PKT)
      begin
        chk(32'(tx_q.size() > 0), 1);
        if (tx_q.size() > 0)
          chk(tx_data, tx_q.pop_front());
        chk(tx_seq, exp_seq);
        exp_seq = exp_seq + 1'b1;
      end
      if (tx_os_valid && tx_ready && tx_os_type == OS_MSG)
        msg_n++;
      if (tx_os_valid && tx_ready && tx_os_type == OS_MSG)
        chk(tx_data, ERR_CORR_CODE);
      if (rx_pkt_valid)
        chk(32'(rx_q.size() > 0), 1);
      if (rx_pkt_valid && rx_q.size() > 0)
        chk(rx_pkt_data, rx_q.pop_front());
    end

  // a hang must still reach the verdict
  initial
  begin
    #500000;
    n_fail++;
    $display("[FAIL] %0t ns: run did not finish", $time);
    summarize();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    i = $urandom(32162);
    tick(8);
    sys_rst = 1'b0;
    cfg_enter = 1'b1;
    tick(2);
    cfg_enter = 1'b0;
    tick(3);
    chk(tx_os_valid, 1);
    chk(tx_lane, PAD_LANE);
    chk(tx_link, LINK_NUM);
    width_settled = 1'b1;
    tick(4);
    chk(tx_lane, LANE_NUM);
    ts(OS_TS2, LINK_NUM, LANE_NUM, 8);
    chk(ltssm_state, ST_L0);
    done("config");
    // packet then idle sets, then a duplicate of seq 1
    for (i = 0; i < 4; i++)
    begin
      k = $urandom;
      if (i != 2)
        rx_q.push_back(k);
      p.send(OS_PKT, LINK_NUM, LANE_NUM, SEQ_W'(i - (i > 1)), k);
      if (i == 0)
        repeat (2) p.send(OS_EIOS, LINK_NUM, LANE_NUM, '0, '0);
    end
    ts(OS_SKP, LINK_NUM, LANE_NUM, 0);
    chk(rx_q.size(), 0);
    done("receive");
    stall = 1'b1;
    tick(2);
    push_n(12, 12, k);
    chk(32'(k >= FIFO_DEPTH && k <= FIFO_DEPTH + 1), 1);
    stall = 1'b0;
    slow = 1'b1;
    for (i = 0; i < 400 && tx_q.size() > 0; i++) tick(1);
    chk(tx_q.size(), 0);
    done("buffer");
    tick(150);
    chk(ltssm_state, ST_L0);
    link_ctrl = {1'($urandom), 1'b1};
    ext_synch = 1'b1;
    // clock enable low must hold off the idle timer
    ce = 1'b0;
    tick(150);
    chk(ltssm_state, ST_L0);
    ce = 1'b1;
    tick(150);
    chk(ltssm_state, ST_L0S);
    f0 = p.fts_n;
    s0 = p.skp_n;
    push_n(1, 20, k);
    for (i = 0; i < 20000 && ltssm_state != ST_L0; i++) tick(1);
    link_ctrl = 2'h0;
    for (i = 0; i < 400 && tx_q.size() > 0; i++) tick(1);
    chk(tx_q.size(), 0);
    chk(p.fts_n - f0, 32'(FTS_EXT));
    chk(32'(p.skp_n - s0 >= SKP_MIN), 1);
    chk(p.timed_out, 0);
    done("l0s exit");
    ext_synch = 1'b0;
    link_ctrl = 2'h1;
    tick(150);
    chk(ltssm_state, ST_L0S);
    f0 = p.fts_n;
    push_n(1, 20, k);
    for (i = 0; i < 2000 && ltssm_state != ST_L0; i++) tick(1);
    link_ctrl = 2'h0;
    for (i = 0; i < 400 && tx_q.size() > 0; i++) tick(1);
    chk(tx_q.size(), 0);
    chk(p.fts_n - f0, 32'(FTS_NORM));
    done("l0s normal");
    slow = 1'b0;
    ack_en = 1'b0;
    f0 = msg_n;
    rx_decode_err = 1'b1;
    tick(1);
    rx_decode_err = 1'b0;
    got = 1'b0;
    for (i = 0; i < 1500 && !got; i++)
    begin
      tick(1);
      got = (retrain_req === 1'b1);
    end
    chk(got, 1);
    chk(msg_n - f0, 32'(REPLAY_NUM) + 1);
    tick(2);
    chk(ltssm_state, ST_REC_LOCK);
    done("replay");
    ack_en = 1'b1;
    ts(OS_TS1, 8'h05, LANE_NUM, 10);
    chk(ltssm_state, ST_REC_LOCK);
    ts(OS_TS1, LINK_NUM, LANE_NUM, 8);
    chk(ltssm_state, ST_REC_CFG);
    ts(OS_TS2, LINK_NUM, LANE_NUM, 7);
    ts(OS_TS2, LINK_NUM, 8'h03, 1);
    chk(ltssm_state, ST_REC_CFG);
    ts(OS_TS2, LINK_NUM, LANE_NUM, 8);
    chk(ltssm_state, ST_L0);
    // skip and eieos between the two sets must not hide the second
    ts(OS_ACK, LINK_NUM, LANE_NUM, 1);
    ts(OS_TS1, LINK_NUM, LANE_NUM, 1);
    ts(OS_SKP, LINK_NUM, LANE_NUM, 1);
    ts(OS_EIEOS, LINK_NUM, LANE_NUM, 1);
    // message left unanswered so no ack breaks the run
    ack_en = 1'b0;
    rx_decode_err = 1'b1;
    tick(1);
    rx_decode_err = 1'b0;
    tick(4);
    chk(ltssm_state, ST_L0);
    ts(OS_TS1, LINK_NUM, LANE_NUM, 1);
    chk(ltssm_state, ST_REC_LOCK);
    done("recovery");
    summarize();
  end
endmodule
